/* File: mode_priv_pkg.sv */
// package: constants, slot layout and state encodings for the mode/privilege/exception block
`default_nettype none
package mode_priv_pkg;
  ////////////////////////////////////////////////////////////////
  // exception slots: fault, supervisor call, pendable service request, then external lines
  localparam int MAX_IRQ = 32;
  localparam int SLOT_FAULT = 0;
  localparam int SLOT_SVC = 1;
  localparam int SLOT_PENDABLE_SERVICE_REQUEST = 2;
  localparam int SLOT_IRQ0 = 3;
  localparam int N_SLOT = SLOT_IRQ0 + MAX_IRQ;
  ////////////////////////////////////////////////////////////////
  // exception numbers: 0 means thread, reset owns word 1 of the table
  localparam int EXC_NUM_W = 8;
  localparam logic [EXC_NUM_W-1:0] EXC_NUM_THREAD = 8'h00;
  localparam logic [EXC_NUM_W-1:0] EXC_NUM_FIRST = 8'h02;
  localparam int VEC_WORD_SHIFT = 2;
  localparam logic [31:0] VEC_OFS_INIT_SP = 32'h0000_0000;
  localparam logic [31:0] VEC_OFS_RESET = 32'h0000_0004;
  ////////////////////////////////////////////////////////////////
  // system address regions
  localparam logic [31:0] SYS_BASE = 32'he000_0000;
  localparam logic [31:0] SYS_LAST = 32'hffff_ffff;
  localparam logic [31:0] PRIV_LAST = 32'he00f_ffff;
  localparam logic [31:0] SCS_BASE = 32'he000_e000;
  localparam logic [31:0] SCS_LAST = 32'he000_efff;
  ////////////////////////////////////////////////////////////////
  // reset values
  localparam logic RST_UNPRIV = 1'b0;
  localparam logic RST_SPSEL = 1'b0;
  ////////////////////////////////////////////////////////////////
  // per-exception state
  typedef enum logic [3:0] {
    EXC_INACTIVE = 4'b0001,
    EXC_PENDING = 4'b0010,
    EXC_ACTIVE = 4'b0100,
    EXC_ACT_PEND = 4'b1000
  } exc_state_e;
  // sequencer state
  typedef enum logic [4:0] {
    SEQ_BOOT_SP = 5'b00001,
    SEQ_BOOT_PC = 5'b00010,
    SEQ_IDLE = 5'b00100,
    SEQ_PUSH = 5'b01000,
    SEQ_VEC = 5'b10000
  } seq_state_e;
endpackage
`default_nettype wire

/* File: exc_state_cell.sv */
// module: state tracker for one non-reset exception
`default_nettype none
module exc_state_cell #(
  parameter bit IS_SYNC = 1'b0
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // events and sequencer strobes
  input wire logic event_i,
  input wire logic take_i,
  input wire logic ret_i,
  input wire logic reenter_i,
  // state
  output logic pend_o,
  output logic act_o,
  output logic pend_nx_o,
  output logic act_nx_o,
  output logic collide_o
);
  mode_priv_pkg::exc_state_e state_q, state_d;

  ////////////////////////////////////////////////////////////////
  // next state: a new event in the clearing cycle is kept, except on take of a synchronous kind, which drops it and flags a collision
  always_comb begin
    state_d = state_q;
    collide_o = 1'b0;
    unique case (state_q)
      mode_priv_pkg::EXC_INACTIVE: begin
        if (event_i) state_d = mode_priv_pkg::EXC_PENDING;
      end
      mode_priv_pkg::EXC_PENDING: begin
        if (take_i) begin
          state_d = mode_priv_pkg::EXC_ACTIVE;
          if (event_i && !IS_SYNC) state_d = mode_priv_pkg::EXC_ACT_PEND;
          collide_o = event_i && IS_SYNC;
        end
      end
      mode_priv_pkg::EXC_ACTIVE: begin
        if (ret_i) begin
          state_d = event_i ? mode_priv_pkg::EXC_PENDING : mode_priv_pkg::EXC_INACTIVE;
        end else if (event_i) begin
          // synchronous kinds never stack a second instance
          if (!IS_SYNC) state_d = mode_priv_pkg::EXC_ACT_PEND;
          collide_o = IS_SYNC;
        end
      end
      mode_priv_pkg::EXC_ACT_PEND: begin
        if (ret_i) begin
          state_d = reenter_i ? mode_priv_pkg::EXC_ACTIVE : mode_priv_pkg::EXC_PENDING;
          if (reenter_i && event_i) state_d = mode_priv_pkg::EXC_ACT_PEND;
        end
      end
      default: state_d = mode_priv_pkg::EXC_INACTIVE;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q <= mode_priv_pkg::EXC_INACTIVE;
    end else begin
      state_q <= state_d;
    end
  end

  assign pend_o = state_q[1] | state_q[3];
  assign act_o = state_q[2] | state_q[3];
  assign pend_nx_o = state_d[1] | state_d[3];
  assign act_nx_o = state_d[2] | state_d[3];
endmodule
`default_nettype wire

/* File: mode_privilege_exception_state.sv */
// module: mode, privilege, stack selection and exception state control
// Behaviour
// - reset enters thread mode; exception return enters it when returning to thread
// - exception enters handler; returns only from handler
// - without privilege extension everything is privileged
// - handler mode is always privileged
// - thread privilege follows the unprivileged control bit
// - two stack pointers; handler uses main
// - system space from e0000000; first megabyte private
// - decode 4kB system control space window
// - at most 32 external interrupt inputs
// - handlers come from a vector table
// - reset abandons work, restarts at fixed point
// - supervisor call raised synchronously, program order
// - synchronous fault reported with its instruction
// - faults fatal, no recovery status given
// - everything else is an asynchronous interrupt
// - track four states per non-reset exception
// - event makes pending; handler start makes active
// - active-and-pending only for asynchronous exceptions
// - return: active clears, active-pending re-enters or pends
// - preemption stacks context then branches via vector
// - reset selects and initialises main stack pointer
`default_nettype none
module mode_privilege_exception_state #(
  parameter bit HAS_PRIV_EXT = 1'b1,
  parameter int NUM_IRQ = 32,
  parameter logic [31:0] RESET_TABLE_BASE = 32'h0000_0000
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // exception events
  input wire logic [mode_priv_pkg::MAX_IRQ-1:0] irq_i,
  input wire logic pend_sv_set_i,
  input wire logic svc_exec_i,
  input wire logic fault_sync_i,
  input wire logic fault_async_i,
  input wire logic [31:0] fault_pc_i,
  // exception entry
  input wire logic entry_req_i,
  input wire logic [mode_priv_pkg::EXC_NUM_W-1:0] entry_num_i,
  // exception return
  input wire logic return_req_i,
  input wire logic return_to_thread_i,
  input wire logic [mode_priv_pkg::EXC_NUM_W-1:0] return_num_i,
  input wire logic reenter_ok_i,
  // context stacking
  output logic push_req_o,
  input wire logic push_done_i,
  // vector fetch
  input wire logic [31:0] vtor_i,
  output logic vec_req_o,
  output logic [31:0] vec_addr_o,
  input wire logic vec_valid_i,
  input wire logic [31:0] vec_data_i,
  // branch to handler or restart point
  output logic branch_o,
  output logic [31:0] branch_addr_o,
  // control writes
  input wire logic ctrl_wr_i,
  input wire logic ctrl_unpriv_i,
  input wire logic ctrl_spsel_i,
  // mode and stack status
  output logic busy_o,
  output logic handler_mode_o,
  output logic privileged_o,
  output logic unpriv_bit_o,
  output logic psp_sel_o,
  output logic main_sp_load_o,
  output logic [31:0] main_sp_init_o,
  output logic [mode_priv_pkg::EXC_NUM_W-1:0] cur_exc_num_o,
  output logic req_refused_o,
  // exception status
  output logic [mode_priv_pkg::N_SLOT-1:0] pending_o,
  output logic [mode_priv_pkg::N_SLOT-1:0] active_o,
  output logic [31:0] fault_instr_o,
  output logic sync_collide_o,
  // address region probe
  input wire logic [31:0] probe_addr_i,
  output logic region_sys_o,
  output logic region_private_o,
  output logic region_scs_o
);
  localparam int NS = mode_priv_pkg::N_SLOT;
  localparam int NW = mode_priv_pkg::EXC_NUM_W;
  // lines above the limit or above NUM_IRQ are never connected
  localparam int IRQ_USED = (NUM_IRQ > mode_priv_pkg::MAX_IRQ) ? mode_priv_pkg::MAX_IRQ : NUM_IRQ;

  ////////////////////////////////////////////////////////////////
  // decoding shared by entry and return
  function automatic logic [NS-1:0] num_to_slot(input logic [NW-1:0] num);
    logic [NS-1:0] hit;
    hit = '0;
    for (int i = 0; i < NS; i++) begin
      hit[i] = (num == (mode_priv_pkg::EXC_NUM_FIRST + NW'(i)));
    end
    return hit;
  endfunction

  function automatic logic [31:0] vec_of(input logic [31:0] base, input logic [NW-1:0] num);
    return base + (32'(num) << mode_priv_pkg::VEC_WORD_SHIFT);
  endfunction

  ////////////////////////////////////////////////////////////////
  // exception slots
  logic [NS-1:0] slot_event;
  logic [NS-1:0] slot_take;
  logic [NS-1:0] slot_ret;
  logic [NS-1:0] slot_reenter;
  logic [NS-1:0] slot_pend;
  logic [NS-1:0] slot_act;
  logic [NS-1:0] slot_pend_nx;
  logic [NS-1:0] slot_act_nx;
  logic [NS-1:0] slot_collide;

  // faults of either kind are fatal and carry no status word
  assign slot_event[mode_priv_pkg::SLOT_FAULT] = fault_sync_i | fault_async_i;
  assign slot_event[mode_priv_pkg::SLOT_SVC] = svc_exec_i;
  assign slot_event[mode_priv_pkg::SLOT_PENDABLE_SERVICE_REQUEST] = pend_sv_set_i;

  genvar g;
  generate
    for (g = 0; g < mode_priv_pkg::MAX_IRQ; g++) begin : g_irq
      if (g < IRQ_USED) begin : g_on
        assign slot_event[mode_priv_pkg::SLOT_IRQ0 + g] = irq_i[g];
      end else begin : g_off
        assign slot_event[mode_priv_pkg::SLOT_IRQ0 + g] = 1'b0;
      end
    end
    for (g = 0; g < NS; g++) begin : g_slot
      exc_state_cell #(
        .IS_SYNC((g == mode_priv_pkg::SLOT_FAULT) || (g == mode_priv_pkg::SLOT_SVC))
      ) u_cell (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .event_i(slot_event[g]),
        .take_i(slot_take[g]),
        .ret_i(slot_ret[g]),
        .reenter_i(slot_reenter[g]),
        .pend_o(slot_pend[g]),
        .act_o(slot_act[g]),
        .pend_nx_o(slot_pend_nx[g]),
        .act_nx_o(slot_act_nx[g]),
        .collide_o(slot_collide[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////
  // sequencer: boot fetch, entry, stacking, vector fetch, return
  mode_priv_pkg::seq_state_e seq_q, seq_d;
  logic handler_q, handler_d;
  logic unpriv_q, unpriv_d;
  logic spsel_q, spsel_d;
  logic priv_q, priv_d;
  logic psp_q, psp_d;
  logic busy_q, busy_d;
  logic push_q, push_d;
  logic vreq_q, vreq_d;
  logic [31:0] vaddr_q, vaddr_d;
  logic branch_q, branch_d;
  logic [31:0] baddr_q, baddr_d;
  logic spload_q, spload_d;
  logic [31:0] spinit_q, spinit_d;
  logic [NW-1:0] cur_q, cur_d;
  logic refused_q, refused_d;
  logic [NS-1:0] entry_hit;
  logic [NS-1:0] ret_hit;
  logic ret_act_pend;

  always_comb begin
    entry_hit = num_to_slot(entry_num_i);
    ret_hit = num_to_slot(cur_q);
    ret_act_pend = |(ret_hit & slot_act & slot_pend);
    seq_d = seq_q;
    handler_d = handler_q;
    cur_d = cur_q;
    push_d = push_q;
    vreq_d = vreq_q;
    vaddr_d = vaddr_q;
    branch_d = 1'b0;
    baddr_d = baddr_q;
    spload_d = 1'b0;
    spinit_d = spinit_q;
    refused_d = 1'b0;
    slot_take = '0;
    slot_ret = '0;
    slot_reenter = '0;
    unique case (seq_q)
      mode_priv_pkg::SEQ_BOOT_SP: begin
        if (vec_valid_i) begin
          spinit_d = vec_data_i;
          spload_d = 1'b1;
          vaddr_d = RESET_TABLE_BASE + mode_priv_pkg::VEC_OFS_RESET;
          seq_d = mode_priv_pkg::SEQ_BOOT_PC;
        end
      end
      mode_priv_pkg::SEQ_BOOT_PC: begin
        if (vec_valid_i) begin
          vreq_d = 1'b0;
          branch_d = 1'b1;
          baddr_d = vec_data_i;
          seq_d = mode_priv_pkg::SEQ_IDLE;
        end
      end
      mode_priv_pkg::SEQ_IDLE: begin
        // return wins over a same-cycle entry request
        if (return_req_i) begin
          if (!handler_q) begin
            refused_d = 1'b1;
          end else begin
            slot_ret = ret_hit;
            if (ret_act_pend && reenter_ok_i) begin
              slot_reenter = ret_hit;
              vreq_d = 1'b1;
              vaddr_d = vec_of(vtor_i, cur_q);
              seq_d = mode_priv_pkg::SEQ_VEC;
            end else begin
              handler_d = !return_to_thread_i;
              cur_d = return_to_thread_i ? mode_priv_pkg::EXC_NUM_THREAD : return_num_i;
            end
          end
        end else if (entry_req_i) begin
          if (|(entry_hit & slot_pend & ~slot_act)) begin
            slot_take = entry_hit;
            handler_d = 1'b1;
            cur_d = entry_num_i;
            push_d = 1'b1;
            seq_d = mode_priv_pkg::SEQ_PUSH;
          end else begin
            refused_d = 1'b1;
          end
        end
      end
      mode_priv_pkg::SEQ_PUSH: begin
        if (push_done_i) begin
          push_d = 1'b0;
          vreq_d = 1'b1;
          vaddr_d = vec_of(vtor_i, cur_q);
          seq_d = mode_priv_pkg::SEQ_VEC;
        end
      end
      mode_priv_pkg::SEQ_VEC: begin
        if (vec_valid_i) begin
          vreq_d = 1'b0;
          branch_d = 1'b1;
          baddr_d = vec_data_i;
          seq_d = mode_priv_pkg::SEQ_IDLE;
        end
      end
      default: seq_d = mode_priv_pkg::SEQ_IDLE;
    endcase
    busy_d = (seq_d != mode_priv_pkg::SEQ_IDLE);
  end

  ////////////////////////////////////////////////////////////////
  // control bits, privilege and stack selection
  always_comb begin
    unpriv_d = unpriv_q;
    spsel_d = spsel_q;
    // unprivileged code cannot raise its own privilege
    if (ctrl_wr_i && priv_q) begin
      unpriv_d = HAS_PRIV_EXT ? ctrl_unpriv_i : mode_priv_pkg::RST_UNPRIV;
      spsel_d = ctrl_spsel_i;
    end
    priv_d = !HAS_PRIV_EXT || handler_d || !unpriv_d;
    psp_d = !handler_d && spsel_d;
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      seq_q <= mode_priv_pkg::SEQ_BOOT_SP;
      handler_q <= 1'b0;
      unpriv_q <= mode_priv_pkg::RST_UNPRIV;
      spsel_q <= mode_priv_pkg::RST_SPSEL;
      priv_q <= 1'b1;
      psp_q <= 1'b0;
      busy_q <= 1'b1;
      push_q <= 1'b0;
      vreq_q <= 1'b1;
      vaddr_q <= RESET_TABLE_BASE + mode_priv_pkg::VEC_OFS_INIT_SP;
      branch_q <= 1'b0;
      baddr_q <= '0;
      spload_q <= 1'b0;
      spinit_q <= '0;
      cur_q <= mode_priv_pkg::EXC_NUM_THREAD;
      refused_q <= 1'b0;
    end else begin
      seq_q <= seq_d;
      handler_q <= handler_d;
      unpriv_q <= unpriv_d;
      spsel_q <= spsel_d;
      priv_q <= priv_d;
      psp_q <= psp_d;
      busy_q <= busy_d;
      push_q <= push_d;
      vreq_q <= vreq_d;
      vaddr_q <= vaddr_d;
      branch_q <= branch_d;
      baddr_q <= baddr_d;
      spload_q <= spload_d;
      spinit_q <= spinit_d;
      cur_q <= cur_d;
      refused_q <= refused_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  // status: exception states, fault address, collisions, regions
  logic [NS-1:0] pend_q;
  logic [NS-1:0] act_q;
  logic [31:0] finstr_q, finstr_d;
  logic collide_q, collide_d;
  logic rsys_q, rpriv_q, rscs_q;
  logic rsys, rpriv, rscs;

  always_comb begin
    finstr_d = fault_sync_i ? fault_pc_i : finstr_q;
    collide_d = |slot_collide;
  end

  sys_region_decode u_region (
    .addr_i(probe_addr_i),
    .system_o(rsys),
    .private_o(rpriv),
    .scs_o(rscs)
  );

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pend_q <= '0;
      act_q <= '0;
      finstr_q <= '0;
      collide_q <= 1'b0;
      rsys_q <= 1'b0;
      rpriv_q <= 1'b0;
      rscs_q <= 1'b0;
    end else begin
      pend_q <= slot_pend_nx;
      act_q <= slot_act_nx;
      finstr_q <= finstr_d;
      collide_q <= collide_d;
      rsys_q <= rsys;
      rpriv_q <= rpriv;
      rscs_q <= rscs;
    end
  end

  ////////////////////////////////////////////////////////////////
  // outputs
  assign push_req_o = push_q;
  assign vec_req_o = vreq_q;
  assign vec_addr_o = vaddr_q;
  assign branch_o = branch_q;
  assign branch_addr_o = baddr_q;
  assign busy_o = busy_q;
  assign handler_mode_o = handler_q;
  assign privileged_o = priv_q;
  assign unpriv_bit_o = unpriv_q;
  assign psp_sel_o = psp_q;
  assign main_sp_load_o = spload_q;
  assign main_sp_init_o = spinit_q;
  assign cur_exc_num_o = cur_q;
  assign req_refused_o = refused_q;
  assign pending_o = pend_q;
  assign active_o = act_q;
  assign fault_instr_o = finstr_q;
  assign sync_collide_o = collide_q;
  assign region_sys_o = rsys_q;
  assign region_private_o = rpriv_q;
  assign region_scs_o = rscs_q;
endmodule
`default_nettype wire

/* File: sys_region_decode.sv */
// module: decode of the reserved system address regions
`default_nettype none
module sys_region_decode (
  // address
  input wire logic [31:0] addr_i,
  // region hits
  output logic system_o,
  output logic private_o,
  output logic scs_o
);
  // the system space runs to the top of memory
  assign system_o = (addr_i >= mode_priv_pkg::SYS_BASE) && (addr_i <= mode_priv_pkg::SYS_LAST);
  assign private_o = (addr_i >= mode_priv_pkg::SYS_BASE) && (addr_i <= mode_priv_pkg::PRIV_LAST);
  assign scs_o = (addr_i >= mode_priv_pkg::SCS_BASE) && (addr_i <= mode_priv_pkg::SCS_LAST);
endmodule
`default_nettype wire

/* File: vec_stack_model.sv */
// model: stacking and vector table memory at the far side
`default_nettype none
module vec_stack_model (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // requests from the block
  input wire logic push_req_i,
  input wire logic vec_req_i,
  input wire logic [31:0] vec_addr_i,
  input wire logic slow_i,
  // answers
  output logic push_done_o,
  output logic vec_valid_o,
  output logic [31:0] vec_data_o
);
  logic [1:0] wait_q;
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wait_q <= 2'h0;
      push_done_o <= 1'b0;
      vec_valid_o <= 1'b0;
      vec_data_o <= 32'h0000_0000;
    end else begin
      push_done_o <= 1'b0;
      vec_valid_o <= 1'b0;
      // data toggles while not valid to expose stale reads
      vec_data_o <= ~vec_data_o;
      if ((push_req_i || vec_req_i) && !push_done_o && !vec_valid_o) begin
        if (wait_q >= (slow_i ? 2'h3 : 2'h0)) begin
          wait_q <= 2'h0;
          push_done_o <= push_req_i;
          vec_valid_o <= !push_req_i;
          // each table word is a pattern of its own address
          if (!push_req_i) vec_data_o <= {16'h2000, vec_addr_i[15:0]};
        end else begin
          wait_q <= wait_q + 2'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: mode_priv_monitor.sv */
// checker: mode, privilege and exception state at the top ports
`default_nettype none
module mode_priv_monitor (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // watched signals
  input wire logic [mode_priv_pkg::MAX_IRQ-1:0] irq_i,
  input wire logic fault_sync_i,
  input wire logic [31:0] fault_pc_i,
  input wire logic entry_req_i,
  input wire logic [mode_priv_pkg::EXC_NUM_W-1:0] entry_num_i,
  input wire logic return_req_i,
  input wire logic push_done_i,
  input wire logic [31:0] vtor_i,
  input wire logic vec_valid_i,
  input wire logic [31:0] vec_data_i,
  input wire logic [31:0] probe_addr_i,
  input wire logic push_req_o,
  input wire logic vec_req_o,
  input wire logic [31:0] vec_addr_o,
  input wire logic branch_o,
  input wire logic [31:0] branch_addr_o,
  input wire logic busy_o,
  input wire logic handler_mode_o,
  input wire logic privileged_o,
  input wire logic unpriv_bit_o,
  input wire logic psp_sel_o,
  input wire logic [mode_priv_pkg::EXC_NUM_W-1:0] cur_exc_num_o,
  input wire logic req_refused_o,
  input wire logic [mode_priv_pkg::N_SLOT-1:0] pending_o,
  input wire logic [mode_priv_pkg::N_SLOT-1:0] active_o,
  input wire logic [31:0] fault_instr_o,
  input wire logic region_scs_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  logic [7:0] eslot;
  logic ent_ok;
  assign eslot = entry_num_i - mode_priv_pkg::EXC_NUM_FIRST;
  assign ent_ok = (int'(eslot) < mode_priv_pkg::N_SLOT) && pending_o[eslot] && !active_o[eslot];
  sequence stack_done; push_req_o && push_done_i; endsequence
  sequence fetch_vec; !push_req_o && vec_req_o && vec_addr_o == vtor_i + {22'h0, cur_exc_num_o, 2'b00}; endsequence
  sequence vec_hit; vec_req_o && vec_valid_i && handler_mode_o; endsequence
  handler_priv_a: assert property (handler_mode_o |-> privileged_o && !psp_sel_o)
    else $error("handler mode not privileged on main stack");
  thread_priv_a: assert property (!handler_mode_o |-> privileged_o == !unpriv_bit_o)
    else $error("thread privilege wrong");
  mode_num_a: assert property (handler_mode_o == (cur_exc_num_o != mode_priv_pkg::EXC_NUM_THREAD))
    else $error("mode and exception number disagree");
  entry_take_a: assert property (!busy_o && !return_req_i && entry_req_i && ent_ok
    |=> handler_mode_o && push_req_o && cur_exc_num_o == $past(entry_num_i)) else $error("entry not taken");
  thread_ret_a: assert property (!busy_o && return_req_i && !handler_mode_o
    |=> req_refused_o && !handler_mode_o) else $error("return in thread not refused");
  stack_fetch_a: assert property (stack_done |=> fetch_vec) else $error("no vector fetch after stacking");
  vec_branch_a: assert property (vec_hit |=> branch_o && !busy_o && branch_addr_o == $past(vec_data_i))
    else $error("branch not to vector");
  irq_pend_a: assert property (1 |=>
    !($past(irq_i) & ~pending_o[mode_priv_pkg::N_SLOT-1:mode_priv_pkg::SLOT_IRQ0]))
    else $error("interrupt event not pending");
  sync_state_a: assert property (!(pending_o[1:0] & active_o[1:0]))
    else $error("sync exception active and pending");
  fault_pc_a: assert property (fault_sync_i |=> fault_instr_o == $past(fault_pc_i))
    else $error("fault instruction not captured");
  scs_win_a: assert property (1 |=> region_scs_o == ($past(probe_addr_i[31:12]) == 20'he000e))
    else $error("control space decode wrong");
endmodule
bind mode_privilege_exception_state mode_priv_monitor mode_priv_monitor_i (.mclk_i, .rstn_i, .irq_i,
  .fault_sync_i, .fault_pc_i, .entry_req_i, .entry_num_i, .return_req_i, .push_done_i, .vtor_i, .vec_valid_i,
  .vec_data_i, .probe_addr_i, .push_req_o, .vec_req_o, .vec_addr_o, .branch_o, .branch_addr_o, .busy_o,
  .handler_mode_o, .privileged_o, .unpriv_bit_o, .psp_sel_o, .cur_exc_num_o, .req_refused_o, .pending_o,
  .active_o, .fault_instr_o, .region_scs_o);
`default_nettype wire

/* File: tb.sv */
// testbench: mode, privilege, stack and exception state scenarios
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] VTOR = 32'h0000_0100;
  logic mclk_i = 1'b0, rstn_i = 1'b0, slow_i = 1'b0;
  logic [31:0] irq_i = 32'h0, fault_pc_i = 32'h0, probe_addr_i = 32'h0;
  logic pend_sv_set_i = 1'b0, svc_exec_i = 1'b0, fault_sync_i = 1'b0, fault_async_i = 1'b0;
  logic entry_req_i = 1'b0, return_req_i = 1'b0, return_to_thread_i = 1'b0, reenter_ok_i = 1'b0;
  logic ctrl_wr_i = 1'b0, ctrl_unpriv_i = 1'b0, ctrl_spsel_i = 1'b0;
  logic [7:0] entry_num_i = 8'h00;
  logic push_req_o, push_done_i, vec_req_o, vec_valid_i, branch_o, busy_o, handler_mode_o, privileged_o;
  logic unpriv_bit_o, psp_sel_o, main_sp_load_o, req_refused_o, sync_collide_o;
  logic region_sys_o, region_private_o, region_scs_o;
  logic [31:0] vec_addr_o, vec_data_i, branch_addr_o, main_sp_init_o, fault_instr_o;
  logic [7:0] cur_exc_num_o;
  logic [34:0] pending_o, active_o;
  int fail_count = 0, n_tests = 0;
  always #5 mclk_i = ~mclk_i;
  mode_privilege_exception_state mode_privilege_exception_state_i (.mclk_i, .rstn_i, .irq_i, .pend_sv_set_i,
    .svc_exec_i, .fault_sync_i, .fault_async_i, .fault_pc_i, .entry_req_i, .entry_num_i, .return_req_i,
    .return_to_thread_i, .return_num_i(8'h00), .reenter_ok_i, .push_req_o, .push_done_i, .vtor_i(VTOR),
    .vec_req_o, .vec_addr_o, .vec_valid_i, .vec_data_i, .branch_o, .branch_addr_o, .ctrl_wr_i, .ctrl_unpriv_i,
    .ctrl_spsel_i, .busy_o, .handler_mode_o, .privileged_o, .unpriv_bit_o, .psp_sel_o, .main_sp_load_o,
    .main_sp_init_o, .cur_exc_num_o, .req_refused_o, .pending_o, .active_o, .fault_instr_o, .sync_collide_o,
    .probe_addr_i, .region_sys_o, .region_private_o, .region_scs_o);
  vec_stack_model vec_stack_model_i (.mclk_i, .rstn_i, .push_req_i(push_req_o), .vec_req_i(vec_req_o),
    .vec_addr_i(vec_addr_o), .slow_i, .push_done_o(push_done_i), .vec_valid_o(vec_valid_i),
    .vec_data_o(vec_data_i));
  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] vmem(input logic [31:0] a);
    return {16'h2000, a[15:0]};
  endfunction
  function automatic logic [31:0] flags(input int s);
    return 32'({handler_mode_o, privileged_o, psp_sel_o, pending_o[s], active_o[s]});
  endfunction
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick();
    @(negedge mclk_i);
  endtask
  task automatic ev(input logic [35:0] v);
    {irq_i, pend_sv_set_i, svc_exec_i, fault_sync_i, fault_async_i} = v;
    tick();
    {irq_i, pend_sv_set_i, svc_exec_i, fault_sync_i, fault_async_i} = 36'h0;
  endtask
  task automatic enter(input logic [7:0] num);
    entry_num_i = num;
    entry_req_i = 1'b1;
    tick();
    entry_req_i = 1'b0;
  endtask
  task automatic ret(input logic thr, input logic re);
    {return_req_i, return_to_thread_i, reenter_ok_i} = {1'b1, thr, re};
    tick();
    return_req_i = 1'b0;
  endtask
  task automatic ctrl(input logic u, input logic s);
    {ctrl_wr_i, ctrl_unpriv_i, ctrl_spsel_i} = {1'b1, u, s};
    tick();
    ctrl_wr_i = 1'b0;
  endtask
  // bounded wait: a missing branch ends the run
  task automatic wait_branch(input logic [31:0] exp);
    int i;
    for (i = 0; i < 40; i++) begin
      tick();
      if (branch_o === 1'b1) break;
    end
    if (i == 40) begin
      fail_count++;
      conclude();
    end
    chk(branch_addr_o, exp);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_boot();
    repeat (2) tick();
    chk(main_sp_init_o | 32'(main_sp_load_o), vmem(32'h0) | 32'h1);
    wait_branch(vmem(32'h4));
    chk(flags(5) | 32'(cur_exc_num_o), 32'h08);
    $display("test boot done");
  endtask
  task automatic t_stack();
    ctrl(1'b0, 1'b1);
    chk(flags(5), 32'h0c);
    ev(36'h40);
    chk(flags(5), 32'h0e);
    slow_i = 1'b1;
    enter(8'h07);
    chk(flags(5), 32'h19);
    chk(32'({push_req_o, cur_exc_num_o}), 32'h107);
    wait_branch(vmem(VTOR + 32'h1c));
    slow_i = 1'b0;
    ev(36'h40);
    chk(flags(5), 32'h1b);
    ret(1'b0, 1'b1);
    chk(flags(5) | 32'({push_req_o, vec_req_o, 5'h0}), 32'h39);
    wait_branch(vmem(VTOR + 32'h1c));
    ev(36'h40);
    ret(1'b1, 1'b0);
    chk(flags(5) | 32'(cur_exc_num_o), 32'h0e);
    enter(8'h07);
    wait_branch(vmem(VTOR + 32'h1c));
    ret(1'b1, 1'b0);
    chk(flags(5), 32'h0c);
    $display("test stack done");
  endtask
  task automatic t_priv();
    ctrl(1'b1, 1'b0);
    chk(flags(4) | 32'(unpriv_bit_o), 32'h01);
    tick();
    ctrl(1'b0, 1'b1);
    chk(flags(4) | 32'(unpriv_bit_o), 32'h01);
    ev(36'h8);
    enter(8'h04);
    chk(flags(2), 32'h19);
    wait_branch(vmem(VTOR + 32'h10));
    ctrl(1'b0, 1'b0);
    ret(1'b1, 1'b0);
    chk(flags(4) | 32'(unpriv_bit_o), 32'h08);
    $display("test privilege done");
  endtask
  task automatic t_sync();
    ev(36'h4);
    chk(flags(1), 32'h0a);
    enter(8'h03);
    wait_branch(vmem(VTOR + 32'h0c));
    ev(36'h4);
    chk(flags(1) | 32'({sync_collide_o, 5'h0}), 32'h39);
    ret(1'b1, 1'b0);
    fault_pc_i = 32'h0000_1234;
    ev(36'h2);
    chk(fault_instr_o ^ flags(0), 32'h0000_123e);
    enter(8'h02);
    wait_branch(vmem(VTOR + 32'h08));
    ret(1'b1, 1'b0);
    ev(36'h1);
    chk(fault_instr_o ^ flags(0), 32'h0000_123e);
    ret(1'b1, 1'b0);
    chk(32'({req_refused_o, handler_mode_o}), 32'h2);
    enter(8'h06);
    chk(32'({req_refused_o, handler_mode_o}), 32'h2);
    $display("test sync done");
  endtask
  task automatic t_region();
    logic [31:0] a[8] = '{32'he000_0000, 32'hdfff_ffff, 32'he00f_ffff, 32'he010_0000,
                          32'he000_e000, 32'he000_dfff, 32'he000_efff, 32'hffff_ffff};
    logic [2:0] e[8] = '{3'h6, 3'h0, 3'h6, 3'h4, 3'h7, 3'h6, 3'h7, 3'h4};
    foreach (a[k]) begin
      probe_addr_i = a[k];
      tick();
      chk(32'({region_sys_o, region_private_o, region_scs_o}), 32'(e[k]));
    end
    $display("test region done");
  endtask
  initial begin
    repeat (12) tick();
    rstn_i = 1'b1;
    t_boot();
    t_stack();
    t_priv();
    t_sync();
    t_region();
    conclude();
  end
endmodule
`default_nettype wire
